/* File: inc/lcdbs_pkg.sv */
// Shared constants, types and decode helpers for the bias and display buffer.
package lcdbs_pkg;

  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int BUF_WORDS = 20;
  localparam int SEG_COUNT = 40;
  localparam int COM_COUNT = 4;
  localparam int NIB_W     = 4;
  localparam int WORD_W    = 8;

  // Byte offsets of the register map.
  localparam logic [ADDR_W-1:0] BIAS_CTRL_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] BUF_BASE_OFS  = 8'h0c;
  localparam logic [ADDR_W-1:0] BUF_END_OFS   = 8'h5c;

  // Field positions inside bias_control.
  localparam int LRT_MSB = 7;
  localparam int LRT_LSB = 5;
  localparam int HRS_BIT = 4;
  localparam int BSI_BIT = 3;

  // Field positions inside a display buffer word.
  localparam int EVEN_LSB = 0;
  localparam int ODD_LSB  = 4;

  localparam logic [WORD_W-1:0] BIAS_RESET = 8'h00;
  localparam logic [WORD_W-1:0] BUF_RESET  = 8'h00;
  localparam logic [2:0]        LRT_OFF    = 3'h0;

  // Default length of one common time slot in core clock cycles.
  localparam int SLOT_CYCLES_DEF = 65536;

  typedef struct packed {
    logic [2:0] lowResistorOnTime;
    logic       highResistorValueSel;
    logic       biasSourceInternal;
  } lcdbs_bias_s;

  typedef enum {BUS_IDLE, BUS_ANSWER} lcdbs_bus_e;

  function automatic logic isBufAddr(input logic [ADDR_W-1:0] a);
    return (a >= BUF_BASE_OFS) && (a < BUF_END_OFS) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [4:0] bufIndex(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - BUF_BASE_OFS;
    return d[6:2];
  endfunction

endpackage

/* File: logic/lcdbs_slot_timer.sv */
// Divider that steps the common time slot index.
module lcdbs_slot_timer #(
  parameter int SLOT_CYCLES = lcdbs_pkg::SLOT_CYCLES_DEF
) (
  input  wire logic       core_clk, // System clock.
  input  wire logic       srst,     // Synchronous reset, active high.
  output logic            slotTick, // One-cycle pulse at each slot change.
  output logic [1:0]      slotIdx   // Current common slot, 0 to 3.
);
  import lcdbs_pkg::*;

  localparam int CNT_W = $clog2(SLOT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SLOT_CYCLES - 1);

  logic [CNT_W-1:0] divCnt_r;
  logic [1:0]       slot_r;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      divCnt_r <= '0;
    end else if (divCnt_r == CNT_LAST) begin
      divCnt_r <= '0;
    end else begin
      divCnt_r <= divCnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      slot_r <= 2'h0;
    end else if (divCnt_r == CNT_LAST) begin
      slot_r <= slot_r + 2'h1;
    end
  end

  assign slotTick = (divCnt_r == CNT_LAST);
  assign slotIdx  = slot_r;
endmodule

/* File: logic/lcdbs_seg_mux.sv */
// Picks, for every segment, the bit belonging to the active common slot.
module lcdbs_seg_mux (
  input  wire logic [lcdbs_pkg::BUF_WORDS-1:0][lcdbs_pkg::WORD_W-1:0]
                    bufWords,                      // Display buffer words.
  input  wire logic [1:0] slotIdx,                 // Active common slot.
  output logic [lcdbs_pkg::SEG_COUNT-1:0] segLevel // Segment on levels.
);
  import lcdbs_pkg::*;

  always_comb begin
    segLevel = '0;
    for (int k = 0; k < BUF_WORDS; k++) begin
      // Nibble bit n belongs to common line n.
      segLevel[2*k]   = bufWords[k][EVEN_LSB + int'(slotIdx)];
      segLevel[2*k+1] = bufWords[k][ODD_LSB + int'(slotIdx)];
    end
  end
endmodule

/* File: logic/lcdbs_top.sv */
// Bias control register and display buffer behind an Avalon-MM slave.
//
// What this block does
// - High-resistance bit low picks the lower bleeder value, high the higher.
// - Bias source bit zero uses external resistors, one the internal network.
// - Low-resistance time and high-value bit act only with internal bias.
// - Twenty buffer words; word k holds segment 2k low, 2k+1 high.
// - Each nibble gives one on/off value per common line slot.
// - Last word holds segments 39 high and 38 low; upper bits read zero.
// - Buffer fields read back as written and drive the display directly.
// - Internal bias releases both external bias pins for port use.
//
// Added by the designer: the address map and the Avalon-MM slave port.
module lcdbs_top #(
  parameter int SLOT_CYCLES = lcdbs_pkg::SLOT_CYCLES_DEF
) (
  input  wire logic                           core_clk,        // Clock.
  input  wire logic                           srst,            // Reset.
  input  wire logic [lcdbs_pkg::ADDR_W-1:0]   avs_address,     // Byte addr.
  input  wire logic                           avs_read,        // Read req.
  input  wire logic                           avs_write,       // Write req.
  input  wire logic [lcdbs_pkg::DATA_W-1:0]   avs_writedata,   // Write data.
  input  wire logic [3:0]                     avs_byteenable,  // Lanes.
  output logic      [lcdbs_pkg::DATA_W-1:0]   avs_readdata,    // Read data.
  output logic                                avs_waitrequest, // Stall.
  output lcdbs_pkg::lcdbs_bias_s              biasCfg,         // To bleeder.
  output logic                                biasPinAAttach,  // Pin a tied.
  output logic                                biasPinBAttach,  // Pin b tied.
  output logic [lcdbs_pkg::SEG_COUNT-1:0]     segmentLine,     // Seg levels.
  output logic [lcdbs_pkg::COM_COUNT-1:0]     commonLine       // Slot 1-hot.
);
  import lcdbs_pkg::*;

  // Bus handshake state and registered answer.
  lcdbs_bus_e        busState_r;
  logic              waitReq_r;
  logic [DATA_W-1:0] readData_r;

  // Software-visible storage.
  logic [WORD_W-1:0]                   biasCtrl_r;
  logic [BUF_WORDS-1:0][WORD_W-1:0]    dispBuf_r;

  // Registered outputs toward the analog and pad side.
  lcdbs_bias_s           biasOut_r;
  logic                  padAttach_r;
  logic [SEG_COUNT-1:0]  segOut_r;
  logic [COM_COUNT-1:0]  comOut_r;

  // Decode and internal nets.
  logic              reqActive;
  logic              accept;
  logic              writeAccept;
  logic              hitBias;
  logic              hitBuf;
  logic [4:0]        bufIdx;
  logic [WORD_W-1:0] readWord;
  logic              internalSel;
  lcdbs_bias_s       biasNxt;
  logic [1:0]        slotIdx;
  logic [SEG_COUNT-1:0] segLevel;

  assign reqActive   = avs_read | avs_write;
  assign hitBias     = (avs_address == BIAS_CTRL_OFS);
  assign hitBuf      = isBufAddr(avs_address);
  assign bufIdx      = bufIndex(avs_address);
  // The master samples waitrequest low on this edge; only then does a
  // write land, so a held request is never applied twice.
  assign accept      = reqActive && (busState_r == BUS_ANSWER);
  assign writeAccept = accept && avs_write && avs_byteenable[0];

  // Every access answers after one wait cycle; unmapped reads return zero
  // and unmapped writes are dropped, so software never hangs the bus.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      busState_r <= BUS_IDLE;
    end else begin
      case (busState_r)
        BUS_IDLE: begin
          if (reqActive) begin
            busState_r <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: begin
          busState_r <= BUS_IDLE;
        end
        default: begin
          busState_r <= BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      waitReq_r <= 1'b1;
    end else if (busState_r == BUS_IDLE && reqActive) begin
      waitReq_r <= 1'b0;
    end else begin
      waitReq_r <= 1'b1;
    end
  end

  always_comb begin
    readWord = '0;
    if (hitBias) begin
      readWord = biasCtrl_r;
    end else if (hitBuf) begin
      readWord = dispBuf_r[bufIdx];
    end
  end

  // Data bits above the low byte always read as zero.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      readData_r <= '0;
    end else if (busState_r == BUS_IDLE && avs_read) begin
      readData_r <= {{(DATA_W-WORD_W){1'b0}}, readWord};
    end
  end

  // Bits 2..0 of the bias control register are reserved and stay zero.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      biasCtrl_r <= BIAS_RESET;
    end else if (writeAccept && hitBias) begin
      biasCtrl_r[LRT_MSB:LRT_LSB] <= avs_writedata[LRT_MSB:LRT_LSB];
      biasCtrl_r[HRS_BIT]         <= avs_writedata[HRS_BIT];
      biasCtrl_r[BSI_BIT]         <= avs_writedata[BSI_BIT];
    end
  end

  // Only the low byte lane carries buffer data.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dispBuf_r <= {BUF_WORDS{BUF_RESET}};
    end else if (writeAccept && hitBuf) begin
      dispBuf_r[bufIdx] <= avs_writedata[WORD_W-1:0];
    end
  end

  assign internalSel = biasCtrl_r[BSI_BIT];

  // With external bias the internal network is unused, so its settings
  // are forced to their inactive values rather than passed on.
  always_comb begin
    biasNxt.biasSourceInternal   = internalSel;
    biasNxt.highResistorValueSel = 1'b0;
    biasNxt.lowResistorOnTime    = LRT_OFF;
    if (internalSel) begin
      biasNxt.highResistorValueSel = biasCtrl_r[HRS_BIT];
      biasNxt.lowResistorOnTime    = biasCtrl_r[LRT_MSB:LRT_LSB];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      biasOut_r <= '0;
    end else begin
      biasOut_r <= biasNxt;
    end
  end

  // After reset external bias is selected, so the pins start attached.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      padAttach_r <= 1'b1;
    end else begin
      padAttach_r <= ~internalSel;
    end
  end

  lcdbs_slot_timer #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_slot_timer (
    .core_clk (core_clk),
    .srst     (srst),
    .slotTick (),
    .slotIdx  (slotIdx)
  );

  lcdbs_seg_mux u_seg_mux (
    .bufWords (dispBuf_r),
    .slotIdx  (slotIdx),
    .segLevel (segLevel)
  );

  // Segments follow the buffer every cycle, so a write shows on the very
  // next edge instead of waiting for the slot to change.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      segOut_r <= '0;
    end else begin
      segOut_r <= segLevel;
    end
  end

  // Common strobe moves with the slot index, one edge late to stay aligned
  // with the registered segment levels.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      comOut_r <= '0;
    end else begin
      comOut_r <= COM_COUNT'(1) << slotIdx;
    end
  end

  assign avs_readdata    = readData_r;
  assign avs_waitrequest = waitReq_r;
  assign biasCfg         = biasOut_r;
  assign biasPinAAttach  = padAttach_r;
  assign biasPinBAttach  = padAttach_r;
  assign segmentLine     = segOut_r;
  assign commonLine      = comOut_r;

endmodule

/* File: verif/lcdbs_props.sv */
// Checker for bus answers, bias outputs and the common slot rotation.
module lcdbs_props #(
  parameter int SLOT_CYCLES = lcdbs_pkg::SLOT_CYCLES_DEF
) (
  input wire logic                   core_clk,        // Clock.
  input wire logic                   srst,            // Reset.
  input wire logic                   avs_read,        // Read request.
  input wire logic                   avs_write,       // Write request.
  input wire logic [31:0]            avs_readdata,    // Read data.
  input wire logic                   avs_waitrequest, // Stall.
  input wire lcdbs_pkg::lcdbs_bias_s biasCfg,         // Bias settings.
  input wire logic                   biasPinAAttach,  // Pin a tied.
  input wire logic                   biasPinBAttach,  // Pin b tied.
  input wire logic [3:0]             commonLine       // Active common.
);
  timeunit 1ns;
  timeprecision 1ps;
  import lcdbs_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  int slotCnt_r;
  // Counts cycles since the last slot change, so slot length can be checked.
  always_ff @(posedge core_clk) begin
    if (srst || commonLine != $past(commonLine)) slotCnt_r <= 0;
    else slotCnt_r <= slotCnt_r + 1;
  end
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
  property p_answer; s_req |-> ##[1:2] s_ans; endproperty
  property p_readZero; avs_readdata[31:8] == 24'h000000; endproperty
  property p_gate; !biasCfg.biasSourceInternal |-> biasCfg == 5'h00;
  endproperty
  property p_pinPair; biasPinAAttach == biasPinBAttach; endproperty
  property p_pinSrc; biasPinAAttach == !biasCfg.biasSourceInternal;
  endproperty
  property p_hot; $onehot0(commonLine); endproperty
  property p_rot; $changed(commonLine) && $past(commonLine) != 4'h0 |->
    commonLine == (($past(commonLine) << 1) | ($past(commonLine) >> 3));
  endproperty
  property p_slotLen; $changed(commonLine) && $past(commonLine) != 4'h0
    |-> slotCnt_r == SLOT_CYCLES - 1; endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  a_readZero: assert property (p_readZero) else $error("upper bits");
  a_gate: assert property (p_gate) else $error("bias not gated");
  a_pinPair: assert property (p_pinPair) else $error("pins differ");
  a_pinSrc: assert property (p_pinSrc) else $error("pin vs source");
  a_hot: assert property (p_hot) else $error("common not one-hot");
  a_rot: assert property (p_rot) else $error("common order");
  a_slotLen: assert property (p_slotLen) else $error("slot length");
endmodule

bind lcdbs_top lcdbs_props #(.SLOT_CYCLES(SLOT_CYCLES)) i_props (
  .core_clk(core_clk), .srst(srst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .biasCfg(biasCfg),
  .biasPinAAttach(biasPinAAttach), .biasPinBAttach(biasPinBAttach),
  .commonLine(commonLine));

/* File: verif/lcdbs_panel.sv */
// Panel model: keeps the segment pattern seen in each common slot.
module lcdbs_panel (
  input wire logic          core_clk,          // Clock.
  input wire logic [39:0]   segmentLine,       // Segment levels.
  input wire logic [3:0]    commonLine,        // Active common.
  output logic [3:0][39:0]  pixel              // Pattern per common.
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge core_clk) begin
    for (int c = 0; c < 4; c++) begin
      if (commonLine[c]) pixel[c] <= segmentLine;
    end
  end
endmodule

/* File: verif/lcdbs_tb_top.sv */
// Self-checking bench for the bias control and display buffer block.
module lcdbs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lcdbs_pkg::*;
  localparam int SLOTS = 8;
  logic core_clk = 1'b0, srst = 1'b1, rdE = 1'b0, wrE = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, got;
  logic [3:0] be = 4'h0, com;
  logic wreq, pinA, pinB;
  logic [39:0] seg;
  logic [3:0][39:0] pix;
  lcdbs_bias_s bias;
  logic [7:0] bv [4] = '{8'hff, 8'hf0, 8'h0f, 8'h18};
  logic [7:0] pv;
  int n_mismatch = 0, n_checks = 0;
  always #2.5 core_clk = ~core_clk;
  lcdbs_top #(.SLOT_CYCLES(SLOTS)) i_dut (.core_clk(core_clk), .srst(srst),
    .avs_address(adr), .avs_read(rdE), .avs_write(wrE),
    .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .biasCfg(bias), .biasPinAAttach(pinA),
    .biasPinBAttach(pinB), .segmentLine(seg), .commonLine(com));
  lcdbs_panel i_panel (.core_clk(core_clk), .segmentLine(seg),
    .commonLine(com), .pixel(pix));
  function automatic logic [7:0] pat(input int k);
    return 8'(k * 29 + 53);
  endfunction
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Holds the request until waitrequest is seen low, then releases it.
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] e);
    int n;
    n = 0;
    adr <= a;
    wdat <= d;
    be <= e;
    wrE <= w;
    rdE <= !w;
    do begin
      @(posedge core_clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    got = rdat;
    if (n >= 20) begin
      n_mismatch++;
      end_of_test();
    end
    rdE <= 1'b0;
    wrE <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, 4'h0);
    chk(got, e);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 21; i++) rdChk(8'(8 + 4 * i), 32'h0);
    chk({pinA, pinB, bias}, 7'h60);
    $display("reset test done");
    for (int k = 0; k < 20; k++) begin
      acc(1'b1, 8'(12 + 4 * k), {24'hffffff, pat(k)}, 4'hf);
    end
    for (int k = 0; k < 20; k++) begin
      rdChk(8'(12 + 4 * k), {24'h0, pat(k)});
    end
    repeat (4 * SLOTS + 4) @(posedge core_clk);
    for (int k = 0; k < 20; k++) begin
      pv = pat(k);
      for (int c = 0; c < 4; c++) begin
        chk({pix[c][2*k+1], pix[c][2*k]}, {pv[4+c], pv[c]});
      end
    end
    $display("buffer test done");
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, BIAS_CTRL_OFS, {24'hffffff, bv[i]}, 4'h1);
      rdChk(BIAS_CTRL_OFS, {24'h0, bv[i] & 8'hf8});
      chk(bias, bv[i][3] ? {bv[i][7:4], 1'b1} : 5'h00);
      chk({pinA, pinB}, {2{!bv[i][3]}});
    end
    $display("bias test done");
    acc(1'b1, 8'h0c, 32'h000000aa, 4'h0);
    acc(1'b1, 8'h0d, 32'h000000aa, 4'hf);
    acc(1'b1, 8'h5c, 32'h000000aa, 4'hf);
    rdChk(8'h0c, {24'h0, pat(0)});
    rdChk(8'h5c, 32'h0);
    rdChk(8'h04, 32'h0);
    $display("refusal test done");
    end_of_test();
  end
endmodule
